// *** logic/secp_pkg.sv ***
// shared constants and types for the serial memory command port
package secp_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL_STATUS = 12'h260;
  localparam logic [11:0] OFS_XFER_BUF = 12'h264;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h268;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h26c;
  // control/status field positions
  localparam int IDX_LO = 0;
  localparam int IDX_HI = 12;
  localparam int CMD_LO = 13;
  localparam int PRES_LO = 16;
  localparam int PROG_LO = 18;
  localparam int IDX_MSB_BIT = 20;
  localparam int CRC_DIS_BIT = 21;
  localparam int SDAT_LO = 24;
  // status data byte bits, counted inside the byte
  localparam int SD_BUSY = 0;
  localparam int SD_WLATCH = 1;
  localparam logic [7:0] SD_WRITABLE_MASK = 8'h8c;
  // command codes
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_WR_STATUS = 3'h1;
  localparam logic [2:0] CMD_WR_WORD = 3'h2;
  localparam logic [2:0] CMD_RD_WORD = 3'h3;
  localparam logic [2:0] CMD_CLR_WLATCH = 3'h4;
  localparam logic [2:0] CMD_RD_STATUS = 3'h5;
  localparam logic [2:0] CMD_SET_WLATCH = 3'h6;
  localparam logic [2:0] CMD_RSVD = 3'h7;
  // presence codes
  localparam logic [1:0] PRES_ABSENT = 2'h0;
  localparam logic [1:0] PRES_OK = 2'h1;
  localparam logic [1:0] PRES_CRC_BAD = 2'h3;
  // command progress codes
  localparam logic [1:0] PROG_DONE = 2'h0;
  localparam logic [1:0] PROG_BUSY = 2'h1;
  localparam logic [1:0] PROG_DONE_CRC = 2'h2;
  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_CRC = 1;
  localparam int IRQ_W = 2;
  // index of the last byte in the address, word and status phases
  localparam logic [1:0] LAST_ADDR_BYTE = 2'h1;
  localparam logic [1:0] LAST_WORD_BYTE = 2'h3;
  localparam logic [1:0] LAST_STATUS_BYTE = 2'h0;
  // serial clock timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCK_HALF_NS = 100;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYC - 1);
  localparam logic [2:0] BIT_LAST = 3'h7;
  // command sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_FINISH = 3'b100
  } secp_state_t;
endpackage

// *** logic/secp_byte_shifter.sv ***
// one-byte serial shifter, clock mode 0, msb first
`timescale 1ns/1ps
`default_nettype none
module secp_byte_shifter (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // byte request and answer
  input wire logic start,
  input wire logic [7:0] tx_byte,
  output logic done,
  output logic [7:0] rx_byte,
  // serial pins
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // all shifter state in one word
  typedef struct packed {
    logic busy;
    logic [7:0] shift;
    logic [7:0] rx;
    logic [2:0] bit_cnt;
    logic [3:0] div;
    logic sck;
    logic done;
  } secp_shift_t;

  secp_shift_t s_reg, s_next;

  // next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0; // done is a single-cycle pulse
    if (start && !s_reg.busy) begin
      s_next.busy = 1'b1;
      s_next.shift = tx_byte;
      s_next.bit_cnt = 3'h0;
      s_next.div = 4'h0;
      s_next.sck = 1'b0;
    end else if (s_reg.busy) begin
      if (s_reg.div == secp_pkg::SCK_HALF_LAST) begin
        s_next.div = 4'h0;
        if (!s_reg.sck) begin
          // rising edge: the memory's output is sampled here
          s_next.sck = 1'b1;
          s_next.rx = {s_reg.rx[6:0], miso};
        end else begin
          // falling edge: present the next bit
          s_next.sck = 1'b0;
          if (s_reg.bit_cnt == secp_pkg::BIT_LAST) begin
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
          end else begin
            s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
            s_next.shift = {s_reg.shift[6:0], 1'b0};
          end
        end
      end else begin
        s_next.div = s_reg.div + 4'h1;
      end
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign done = s_reg.done;
  assign rx_byte = s_reg.rx;
  assign sck = s_reg.sck;
  assign mosi = s_reg.shift[7];
endmodule
`default_nettype wire

// *** logic/secp_command_port.sv ***
// serial memory command port: wishbone registers and command sequencer
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module secp_command_port (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // presence and integrity from the memory loader
  input wire logic mem_present,
  input wire logic crc_check_bad,
  // serial memory pins
  output logic mem_cs_n,
  output logic mem_sck,
  output logic mem_mosi,
  input wire logic mem_miso,
  // interrupt
  output logic irq
);
  // all block state in one word
  typedef struct packed {
    secp_pkg::secp_state_t st;
    logic [12:0] idx; // word index low bits
    logic idx_msb; // word index bit 13
    logic crc_dis; // crc check override
    logic [2:0] cmd; // last command code written
    logic [7:0] sdat; // status data byte
    logic [1:0] prog; // command progress
    logic [31:0] xbuf; // transfer buffer
    logic [1:0] cnt; // byte counter within a phase
    logic issued; // byte request sent, awaiting done
    logic eng_start;
    logic [7:0] eng_tx;
    logic cs_n;
    logic ack;
    logic [31:0] rdat;
    logic [secp_pkg::IRQ_W-1:0] irq_st;
    logic [secp_pkg::IRQ_W-1:0] irq_mask;
    logic irq;
  } secp_port_t;

  secp_port_t r_reg, r_next;
  logic eng_done;
  logic [7:0] eng_rx;
  logic [1:0] presence;
  logic [31:0] ctrl_word;
  logic [15:0] byte_addr;
  logic req;

  // byte k of a word, used on the send path
  function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] k);
    word_byte = w[8*k +: 8];
  endfunction

  // codes that actually start a memory transaction
  function automatic logic cmd_valid(input logic [2:0] c);
    cmd_valid = (c != secp_pkg::CMD_NONE) && (c != secp_pkg::CMD_RSVD);
  endfunction

  // presence follows the loader; the crc override masks only a bad crc
  always_comb begin
    if (!mem_present) begin
      presence = secp_pkg::PRES_ABSENT;
    end else if (crc_check_bad && !r_reg.crc_dis) begin
      presence = secp_pkg::PRES_CRC_BAD;
    end else begin
      presence = secp_pkg::PRES_OK;
    end
  end

  // byte address of the selected word, 64 KB span with bit 13
  assign byte_addr = {r_reg.idx_msb, r_reg.idx, 2'b00};

  // readback image of the control/status register
  always_comb begin
    ctrl_word = '0; // reserved bits 23:22 read zero
    ctrl_word[secp_pkg::IDX_HI:secp_pkg::IDX_LO] = r_reg.idx;
    ctrl_word[secp_pkg::CMD_LO +: 3] = r_reg.cmd;
    ctrl_word[secp_pkg::PRES_LO +: 2] = presence;
    ctrl_word[secp_pkg::PROG_LO +: 2] = r_reg.prog;
    ctrl_word[secp_pkg::IDX_MSB_BIT] = r_reg.idx_msb;
    ctrl_word[secp_pkg::CRC_DIS_BIT] = r_reg.crc_dis;
    ctrl_word[secp_pkg::SDAT_LO +: 8] = r_reg.sdat;
  end

  assign req = wb_cyc_i && wb_stb_i;

  // next-state logic: bus slave, sequencer, interrupts
  always_comb begin
    r_next = r_reg;
    r_next.eng_start = 1'b0;
    // ack one cycle after the request, dropped the cycle after
    r_next.ack = req && !r_reg.ack;
    // read data captured with the rising ack
    if (req && !r_reg.ack && !wb_we_i) begin
      if (wb_adr_i == secp_pkg::OFS_CTRL_STATUS) begin
        r_next.rdat = ctrl_word;
      end else if (wb_adr_i == secp_pkg::OFS_XFER_BUF) begin
        r_next.rdat = r_reg.xbuf;
      end else if (wb_adr_i == secp_pkg::OFS_IRQ_STATUS) begin
        r_next.rdat = 32'(r_reg.irq_st);
      end else if (wb_adr_i == secp_pkg::OFS_IRQ_MASK) begin
        r_next.rdat = 32'(r_reg.irq_mask);
      end else begin
        r_next.rdat = '0; // unmapped reads zero
      end
    end
    // reading interrupt status clears it; new events below win
    if (req && r_reg.ack && !wb_we_i && wb_adr_i == secp_pkg::OFS_IRQ_STATUS) begin
      r_next.irq_st = '0;
    end
    // writes take effect at the edge where ack is seen
    if (req && r_reg.ack && wb_we_i) begin
      if (wb_adr_i == secp_pkg::OFS_CTRL_STATUS) begin
        // ignored mid-command so the sequencer sees stable fields
        if (r_reg.st == secp_pkg::ST_IDLE) begin
          if (wb_sel_i[0]) begin
            r_next.idx[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            r_next.idx[12:8] = wb_dat_i[12:8];
            r_next.cmd = wb_dat_i[secp_pkg::CMD_LO +: 3];
            if (cmd_valid(wb_dat_i[secp_pkg::CMD_LO +: 3])) begin
              r_next.st = secp_pkg::ST_OPCODE;
              r_next.issued = 1'b0;
              r_next.prog = secp_pkg::PROG_BUSY;
            end
          end
          if (wb_sel_i[2]) begin
            r_next.idx_msb = wb_dat_i[secp_pkg::IDX_MSB_BIT];
            r_next.crc_dis = wb_dat_i[secp_pkg::CRC_DIS_BIT];
          end
          if (wb_sel_i[3]) begin
            r_next.sdat = wb_dat_i[secp_pkg::SDAT_LO +: 8];
          end
        end
      end else if (wb_adr_i == secp_pkg::OFS_XFER_BUF) begin
        if (r_reg.st == secp_pkg::ST_IDLE) begin
          for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
              r_next.xbuf[8*b +: 8] = wb_dat_i[8*b +: 8];
            end
          end
        end
      end else if (wb_adr_i == secp_pkg::OFS_IRQ_MASK) begin
        if (wb_sel_i[0]) begin
          r_next.irq_mask = wb_dat_i[secp_pkg::IRQ_W-1:0];
        end
      end
    end
    // command sequencer; opcodes equal the command codes
    case (r_reg.st)
      secp_pkg::ST_IDLE: begin
        r_next.cs_n = 1'b1;
      end
      secp_pkg::ST_OPCODE: begin
        r_next.cs_n = 1'b0;
        if (!r_reg.issued) begin
          r_next.eng_start = 1'b1;
          r_next.eng_tx = {5'h00, r_reg.cmd};
          r_next.issued = 1'b1;
        end else if (eng_done) begin
          r_next.issued = 1'b0;
          r_next.cnt = 2'h0;
          if (r_reg.cmd == secp_pkg::CMD_WR_WORD || r_reg.cmd == secp_pkg::CMD_RD_WORD) begin
            r_next.st = secp_pkg::ST_ADDR;
          end else if (r_reg.cmd == secp_pkg::CMD_WR_STATUS
                       || r_reg.cmd == secp_pkg::CMD_RD_STATUS) begin
            r_next.st = secp_pkg::ST_DATA;
          end else begin
            r_next.st = secp_pkg::ST_FINISH;
          end
        end
      end
      secp_pkg::ST_ADDR: begin
        if (!r_reg.issued) begin
          r_next.eng_start = 1'b1;
          r_next.eng_tx = (r_reg.cnt == 2'h0) ? byte_addr[15:8] : byte_addr[7:0];
          r_next.issued = 1'b1;
        end else if (eng_done) begin
          r_next.issued = 1'b0;
          if (r_reg.cnt == secp_pkg::LAST_ADDR_BYTE) begin
            r_next.cnt = 2'h0;
            r_next.st = secp_pkg::ST_DATA;
          end else begin
            r_next.cnt = r_reg.cnt + 2'h1;
          end
        end
      end
      secp_pkg::ST_DATA: begin
        if (!r_reg.issued) begin
          r_next.eng_start = 1'b1;
          if (r_reg.cmd == secp_pkg::CMD_WR_WORD) begin
            r_next.eng_tx = word_byte(r_reg.xbuf, r_reg.cnt);
          end else if (r_reg.cmd == secp_pkg::CMD_WR_STATUS) begin
            r_next.eng_tx = r_reg.sdat & secp_pkg::SD_WRITABLE_MASK;
          end else begin
            r_next.eng_tx = 8'h00; // dummy byte while reading
          end
          r_next.issued = 1'b1;
        end else if (eng_done) begin
          r_next.issued = 1'b0;
          if (r_reg.cmd == secp_pkg::CMD_RD_WORD) begin
            r_next.xbuf[8*r_reg.cnt +: 8] = eng_rx;
          end else if (r_reg.cmd == secp_pkg::CMD_RD_STATUS) begin
            r_next.sdat = eng_rx;
          end else if (r_reg.cmd == secp_pkg::CMD_WR_STATUS) begin
            // keep the byte in step with what the memory now holds
            r_next.sdat[secp_pkg::SD_WLATCH] = 1'b0;
          end
          if ((r_reg.cmd == secp_pkg::CMD_WR_WORD || r_reg.cmd == secp_pkg::CMD_RD_WORD)
              ? (r_reg.cnt == secp_pkg::LAST_WORD_BYTE)
              : (r_reg.cnt == secp_pkg::LAST_STATUS_BYTE)) begin
            r_next.st = secp_pkg::ST_FINISH;
          end else begin
            r_next.cnt = r_reg.cnt + 2'h1;
          end
        end
      end
      secp_pkg::ST_FINISH: begin
        // select released here; the memory latches the command now
        r_next.cs_n = 1'b1;
        r_next.st = secp_pkg::ST_IDLE;
        r_next.irq_st[secp_pkg::IRQ_DONE] = 1'b1;
        if (r_reg.cmd == secp_pkg::CMD_CLR_WLATCH) begin
          r_next.sdat[secp_pkg::SD_WLATCH] = 1'b0;
        end else if (r_reg.cmd == secp_pkg::CMD_SET_WLATCH) begin
          r_next.sdat[secp_pkg::SD_WLATCH] = 1'b1;
        end else if (r_reg.cmd == secp_pkg::CMD_WR_WORD) begin
          r_next.sdat[secp_pkg::SD_BUSY] = 1'b1; // internal write begins
          r_next.sdat[secp_pkg::SD_WLATCH] = 1'b0;
        end
        if (r_reg.cmd == secp_pkg::CMD_RD_WORD && crc_check_bad && !r_reg.crc_dis) begin
          r_next.prog = secp_pkg::PROG_DONE_CRC;
          r_next.irq_st[secp_pkg::IRQ_CRC] = 1'b1;
        end else begin
          r_next.prog = secp_pkg::PROG_DONE;
        end
      end
      default: begin
        r_next.st = secp_pkg::ST_IDLE;
      end
    endcase
    // level interrupt from the next status and mask
    r_next.irq = |(r_next.irq_st & r_next.irq_mask);
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.st <= secp_pkg::ST_IDLE;
      r_reg.cs_n <= 1'b1;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // serial byte engine
  secp_byte_shifter u_shifter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .start(r_reg.eng_start),
    .tx_byte(r_reg.eng_tx),
    .done(eng_done),
    .rx_byte(eng_rx),
    .sck(mem_sck),
    .mosi(mem_mosi),
    .miso(mem_miso)
  );

  assign wb_dat_o = r_reg.rdat;
  assign wb_ack_o = r_reg.ack;
  assign mem_cs_n = r_reg.cs_n;
  assign irq = r_reg.irq;
endmodule
`default_nettype wire

// *** testbench/secp_properties.sv ***
// assertion checker bound to the serial memory command port
`timescale 1ns/1ps
`default_nettype none
module secp_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // serial pins and interrupt
  input wire logic mem_cs_n,
  input wire logic mem_sck,
  input wire logic mem_mosi,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // control write acked while the link is idle
  logic ctl_wr;
  assign ctl_wr = wb_ack_o && wb_we_i && wb_sel_i[1] && mem_cs_n
    && wb_adr_i == secp_pkg::OFS_CTRL_STATUS;
  // request steps
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_go;
    ctl_wr && wb_dat_i[15:13] inside {[3'h1:3'h6]};
  endsequence
  sequence s_nop;
    ctl_wr && wb_dat_i[15:13] inside {3'h0, 3'h7};
  endsequence
  sequence s_ctl_rd;
    wb_ack_o && !wb_we_i && wb_adr_i == secp_pkg::OFS_CTRL_STATUS;
  endsequence
  property p_ack_late;
    s_req |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_cmd_start;
    s_go |-> ##[1:4] !mem_cs_n;
  endproperty
  property p_no_start;
    s_nop |=> mem_cs_n [*6];
  endproperty
  property p_sck_sel;
    $rose(mem_sck) |-> !mem_cs_n;
  endproperty
  // mode 0: data must hold while the clock is high
  property p_mosi_hold;
    $rose(mem_sck) |-> $stable(mem_mosi) [*3];
  endproperty
  property p_prog_code;
    s_ctl_rd |-> wb_dat_o[19:18] != 2'h3;
  endproperty
  property p_pres_code;
    s_ctl_rd |-> wb_dat_o[17:16] != 2'h2;
  endproperty
  property p_reset;
    $rose(rst_n) |-> mem_cs_n && !mem_sck && !wb_ack_o && !irq;
  endproperty
  a_ack_late: assert property (p_ack_late) else $error("ack missing");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_cmd_start: assert property (p_cmd_start) else $error("command not started");
  a_no_start: assert property (p_no_start) else $error("null code started");
  a_sck_sel: assert property (p_sck_sel) else $error("clock while deselected");
  a_mosi_hold: assert property (p_mosi_hold) else $error("data moved in high");
  a_prog_code: assert property (p_prog_code) else $error("unused progress code");
  a_pres_code: assert property (p_pres_code) else $error("unused presence code");
  a_reset: assert property (p_reset) else $error("bad reset levels");
endmodule
bind secp_command_port secp_properties u_props (.clk_sys(clk_sys), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .mem_cs_n(mem_cs_n), .mem_sck(mem_sck), .mem_mosi(mem_mosi), .irq(irq));
`default_nettype wire

// *** testbench/secp_mem_model.sv ***
// behavioural serial memory at the far end of the link, mode 0
`timescale 1ns/1ps
`default_nettype none
module secp_mem_model (
  // clock for the write-cycle timer
  input wire logic clk_sys,
  // serial pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // write-cycle length in clocks
  input wire logic [15:0] busy_len
);
  logic [7:0] mem [0:65535]; // array
  logic [7:0] sr; // bit0 busy, bit1 latch
  logic [7:0] op, sh, dout;
  logic [15:0] adr;
  logic drv, wrote;
  int n, k, tmr;
  initial begin
    sr = 8'h0;
    miso = 1'b0;
    tmr = 0;
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i * 7);
  end
  // new frame
  always @(negedge cs_n) begin
    n = 0;
    drv = 1'b0;
    wrote = 1'b0;
  end
  // sample on rise, act per whole byte
  always @(posedge sck) begin
    if (!cs_n) begin
      sh = {sh[6:0], mosi};
      n++;
      k = n / 8;
      if (n % 8 == 0) begin
        if (k == 1) op = sh;
        else if (k < 4 && op inside {8'h02, 8'h03}) adr = {adr[7:0], sh};
        else if (op == 8'h02 && sr[1]) begin
          mem[16'(adr + k - 4)] = sh;
          wrote = 1'b1;
        end
        // keeps bits 7:2 as sent, so stray bits there show up
        else if (op == 8'h01) sr[7:2] = sh[7:2];
        if (k == 1 && op == 8'h06) sr[1] = 1'b1;
        if (k == 1 && op == 8'h04) sr[1] = 1'b0;
        drv = (op == 8'h05) || (op == 8'h03 && k >= 3);
        dout = (op == 8'h05) ? sr : mem[16'(adr + k - 3)];
      end
    end
  end
  // shift out on fall; a released line toggles instead of holding
  always @(negedge sck or posedge cs_n) begin
    if (drv && !cs_n) miso <= dout[7 - n % 8];
    else miso <= ~miso;
  end
  // finished write: internal cycle starts, latch drops
  always @(posedge cs_n) begin
    if (wrote) begin
      sr[0] = 1'b1;
      sr[1] = 1'b0;
      tmr = busy_len;
    end
  end
  // write-cycle timer
  always @(posedge clk_sys) begin
    if (tmr > 0) begin
      tmr--;
      if (tmr == 0) sr[0] = 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the serial memory command port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys, rst_n, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic mem_present, crc_check_bad, mem_cs_n, mem_sck, mem_mosi, mem_miso, irq;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [31:0] words [int]; // expected words
  logic [15:0] busy_len;
  logic [13:0] ix;
  logic [1:0] pr;
  logic [2:0] c;
  int miscompares, checked, cycles;
  secp_command_port DUT (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_present(mem_present),
    .crc_check_bad(crc_check_bad), .mem_cs_n(mem_cs_n), .mem_sck(mem_sck),
    .mem_mosi(mem_mosi), .mem_miso(mem_miso), .irq(irq));
  secp_mem_model u_mem (.clk_sys(clk_sys), .cs_n(mem_cs_n), .sck(mem_sck),
    .mosi(mem_mosi), .miso(mem_miso), .busy_len(busy_len));
  // compare tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one classic wishbone cycle, waits for ack
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    // a missing ack is a mismatch, never a silent pass
    if (wb_ack_o !== 1'b1) miscompares++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // start a command, then poll until it is no longer in progress
  task automatic cmd(input logic [2:0] cc, input logic [13:0] i, input logic [7:0] sd,
                     input logic dis);
    int n;
    n = 0;
    wb(1'b1, secp_pkg::OFS_CTRL_STATUS, {sd, 2'h0, dis, i[13], 4'h0, cc, i[12:0]}, rd);
    do begin
      wb(1'b0, secp_pkg::OFS_CTRL_STATUS, 32'h0, rd);
      n++;
    end while (rd[19:18] === secp_pkg::PROG_BUSY && n < 400);
    // a command that never completes is a mismatch
    if (rd[19:18] === secp_pkg::PROG_BUSY) miscompares++;
  endtask
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // hang guard, far above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 12'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    mem_present = 1'b1;
    crc_check_bad = 1'b0;
    busy_len = 16'd2000;
    void'($urandom(24696));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    // reset value and an unmapped place
    wb(1'b0, secp_pkg::OFS_CTRL_STATUS, 32'h0, rd);
    chk("ctrl_reset", 32'h0001_0000, rd);
    wb(1'b0, 12'h270, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    // presence codes, stored fields, read-only bits, null codes
    for (int k = 0; k < 8; k++) begin
      mem_present <= k[0];
      crc_check_bad <= k[1];
      ix = 14'($urandom);
      c = k[0] ? 3'h7 : 3'h0;
      pr = !k[0] ? 2'h0 : (k[1] && !k[2]) ? 2'h3 : 2'h1;
      wb(1'b1, secp_pkg::OFS_CTRL_STATUS, {10'h0, k[2], ix[13], 4'hf, c, ix[12:0]}, rd);
      wb(1'b0, secp_pkg::OFS_CTRL_STATUS, 32'h0, rd);
      chk("ctrl_fields", {10'h0, k[2], ix[13], 2'h0, pr, c, ix[12:0]}, rd);
    end
    mem_present <= 1'b1;
    crc_check_bad <= 1'b0;
    // enable low freezes a running command, which then completes
    wb(1'b1, secp_pkg::OFS_CTRL_STATUS, {16'h0, secp_pkg::CMD_SET_WLATCH, 13'h0}, rd);
    repeat (9) @(posedge clk_sys);
    ce <= 1'b0;
    @(posedge clk_sys);
    pr = {mem_cs_n, mem_sck};
    repeat (20) @(posedge clk_sys);
    chk("ce_freeze", {30'h0, pr}, {30'h0, mem_cs_n, mem_sck});
    ce <= 1'b1;
    repeat (100) @(posedge clk_sys);
    wb(1'b0, secp_pkg::OFS_CTRL_STATUS, 32'h0, rd);
    chk("ce_resume", {30'h0, secp_pkg::PROG_DONE}, {30'h0, rd[19:18]});
    // latch set then cleared, fetched each time
    for (int k = 0; k < 2; k++) begin
      cmd(k ? secp_pkg::CMD_CLR_WLATCH : secp_pkg::CMD_SET_WLATCH, 14'h0, 8'h0, 1'b0);
      cmd(secp_pkg::CMD_RD_STATUS, 14'h0, 8'h0, 1'b0);
      chk("status_byte", {30'h0, k == 0, 1'b0}, {24'h0, rd[31:24]});
    end
    // two words differing only in the top index bit
    ix = 14'($urandom);
    for (int k = 0; k < 2; k++) begin
      words[k] = $urandom;
      cmd(secp_pkg::CMD_SET_WLATCH, 14'h0, 8'h0, 1'b0);
      wb(1'b1, secp_pkg::OFS_XFER_BUF, words[k], rd);
      cmd(secp_pkg::CMD_WR_WORD, {k[0], ix[12:0]}, 8'h0, 1'b0);
      chk("mem_byte0", {24'h0, words[k][7:0]}, {24'h0, u_mem.mem[{k[0], ix[12:0], 2'b00}]});
      cmd(secp_pkg::CMD_RD_STATUS, 14'h0, 8'h0, 1'b0);
      chk_pin("busy_bit", k == 0, rd[24]);
      busy_len = 16'd20;
    end
    for (int k = 0; k < 2; k++) begin
      cmd(secp_pkg::CMD_RD_WORD, {k[0], ix[12:0]}, 8'h0, 1'b0);
      wb(1'b0, secp_pkg::OFS_XFER_BUF, 32'h0, rd);
      chk("buffer_word", words[k], rd);
    end
    // status write sends only the writable bits
    cmd(secp_pkg::CMD_WR_STATUS, 14'h0, 8'hff, 1'b0);
    chk("mem_status", 32'h8c, {24'h0, u_mem.sr & 8'hfc});
    cmd(secp_pkg::CMD_RD_STATUS, 14'h0, 8'h0, 1'b0);
    chk("status_back", 32'h8c, {24'h0, rd[31:24]});
    // crc failure reported, then suppressed
    crc_check_bad <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      cmd(secp_pkg::CMD_RD_WORD, {1'b0, ix[12:0]}, 8'h0, k[0]);
      chk("crc_status", {28'h0, k ? 4'h1 : 4'hb}, {28'h0, rd[19:16]});
    end
    crc_check_bad <= 1'b0;
    // reset in mid-run brings back the reset image
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    wb(1'b0, secp_pkg::OFS_CTRL_STATUS, 32'h0, rd);
    chk("ctrl_rereset", 32'h0001_0000, rd);
    // done event: unmasked raises the line, status read clears it
    wb(1'b0, secp_pkg::OFS_IRQ_STATUS, 32'h0, rd);
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, secp_pkg::OFS_IRQ_MASK, {31'h0, k == 0}, rd);
      cmd(secp_pkg::CMD_SET_WLATCH, 14'h0, 8'h0, 1'b0);
      repeat (2) @(posedge clk_sys);
      chk_pin("irq_level", k == 0, irq);
      wb(1'b0, secp_pkg::OFS_IRQ_STATUS, 32'h0, rd);
      chk("irq_status", 32'h1, rd & 32'h3);
      repeat (2) @(posedge clk_sys);
      chk_pin("irq_clear", 1'b0, irq);
    end
    conclude();
  end
endmodule
`default_nettype wire
